// ==== core/cpu_regfile_address_gen.sv ====
// Notes on behaviour
// (RULE_01) Immediate-operand instructions reach only registers sixteen to thirty-one.
// (RULE_02) Working registers answer as the lowest 32 data addresses.
// (RULE_03) 224 data locations: 96 register plus I/O, then 128 SRAM.
// (RULE_04) Top six registers pair into three 16-bit pointers.
// (RULE_05) Displacement address is Y or Z plus unsigned 6-bit field.
// (RULE_06) Plain indirect address is the unchanged pointer.
// (RULE_07) Pre-decrement: pointer minus one is address and written back.
// (RULE_08) Post-increment: old pointer is address, then pointer plus one.
// (RULE_09) I/O direct takes its address from a 6-bit instruction field.
// (RULE_10) Direct data address is the 16-bit second instruction word.
// (RULE_11) Constant read: Z upper 15 bits word, bit zero byte select.
// (RULE_12) Pointer jump and call load the program counter from Z.
// (RULE_13) Relative jump and call: PC plus signed offset plus one.
// (RULE_14) Program counter is 10 bits, 1024 words.
// (RULE_15) Two operands read and result written in one cycle.
// (RULE_16) Two-register result goes to the destination register only.
// (RULE_17) Runs straight on the system clock, no divider.
// (RULE_18) SRAM accesses complete in two clock cycles.
// (RULE_19) Pointer update wins over a data write to its own register.
`timescale 1ns/10ps
module cpu_regfile_address_gen
    import regfile_pkg::*;
#(
    parameter int unsigned PC_WIDTH = 10
) (
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_n_i,
    // ALU register port
    input  wire alu_req_t            alu_req_i,
    output logic [7:0]               dst_operand_o,
    output logic [7:0]               source_operand_reg_o,
    output logic                     imm_reg_fault_o,
    // Data access port
    input  wire data_req_t           data_req_i,
    output logic [15:0]              data_addr_o,
    output target_t                  data_target_o,
    output logic [7:0]               data_rd_o,
    output logic                     data_done_o,
    output logic                     data_busy_o,
    // I/O space side
    output logic                     io_wr_o,
    output logic                     io_rd_o,
    output logic [5:0]               io_addr_o,
    output logic [7:0]               io_wr_data_o,
    input  wire logic [7:0]          io_rd_data_i,
    // SRAM side
    output logic                     sram_wr_o,
    output logic                     sram_rd_o,
    output logic [6:0]               sram_addr_o,
    output logic [7:0]               sram_wr_data_o,
    input  wire logic [7:0]          sram_rd_data_i,
    // Program counter control
    input  wire pc_op_t              pc_op_i,
    input  wire logic [11:0]         rel_offset_i,
    output logic [PC_WIDTH-1:0]      pc_o,
    // Program constant address
    output const_addr_t              const_addr_o
);

    // Whole module state
    typedef struct packed {
        // Working registers and program counter
        logic [NUM_REGS-1:0][7:0] regs;
        logic [PC_WIDTH-1:0]      pc;

        // Registered operand reads
        logic [7:0]               dst_q;
        logic [7:0]               src_q;
        logic                     imm_fault;

        // Result of the last accepted access
        logic [15:0]              addr;
        target_t                  target;
        logic [7:0]               rd_data;
        logic                     done;
        logic                     busy;
        logic                     pend_rd;

        // I/O strobes
        logic                     io_wr;
        logic                     io_rd;
        logic [5:0]               io_addr;

        // SRAM strobes
        logic                     sram_wr;
        logic                     sram_rd;
        logic [6:0]               sram_addr;

        // Shared write data, constant address
        logic [7:0]               wr_data;
        const_addr_t              cst;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Pointer path
    logic [15:0] ptr_val;
    logic [15:0] eff_addr;
    logic [15:0] new_ptr;
    logic        ptr_update;
    addr_mode_t  eff_mode;
    logic [4:0]  ptr_lo;

    // Immediate destination check
    logic [4:0]  dst_idx;
    logic        dst_ok;

    // Pointer pair select from the top six registers
    always_comb begin
        case (data_req_i.ptr_sel)
            2'h1:    ptr_lo = 5'(PTR_Y_LO);
            2'h2:    ptr_lo = 5'(PTR_Z_LO);
            default: ptr_lo = 5'(PTR_X_LO);
        endcase

        // Low byte at the even register
        ptr_val = {state_reg.regs[ptr_lo + 5'h01], state_reg.regs[ptr_lo]}; // (RULE_04)

        // X has no displacement form; treat it as plain indirect
        eff_mode = data_req_i.mode;
        if (data_req_i.mode == MODE_DISP && data_req_i.ptr_sel == 2'h0) begin
            eff_mode = MODE_INDIRECT;
        end
    end

    // Address and writeback for the chosen pointer
    ptr_adjust #(
        .WIDTH (16)
    ) u_ptr_adjust (
        .ptr_i     (ptr_val),
        .mode_i    (eff_mode),
        .disp_i    (data_req_i.field6),
        .addr_o    (eff_addr),
        .new_ptr_o (new_ptr),
        .update_o  (ptr_update)
    );

    // Immediate forms only reach the upper half
    always_comb begin
        dst_idx = alu_req_i.dst_sel;
        dst_ok  = 1'b1;
        if (alu_req_i.immediate && dst_idx < 5'(IMM_REG_BASE)) begin
            dst_ok = 1'b0; // (RULE_01)
        end
    end

    // Next state; everything holds unless assigned below
    always_comb begin
        logic [15:0] a;
        logic [PC_WIDTH-1:0] rel;
        a   = 16'h0000;
        rel = '0;
        state_next         = state_reg;

        // Strobes and done are one-cycle pulses
        state_next.done    = 1'b0;
        state_next.io_wr   = 1'b0;
        state_next.io_rd   = 1'b0;
        state_next.sram_wr = 1'b0;
        state_next.sram_rd = 1'b0;

        // Operands read and result written in the same cycle
        state_next.dst_q     = state_reg.regs[alu_req_i.dst_sel]; // (RULE_15)
        state_next.src_q     = state_reg.regs[alu_req_i.src_sel];
        state_next.imm_fault = alu_req_i.immediate && !dst_ok;

        // Immediate write to the lower half dropped, only flagged
        if (alu_req_i.wr_en && dst_ok) begin
            state_next.regs[dst_idx] = alu_req_i.wr_data; // (RULE_16)
        end

        // Second SRAM cycle returns the read data
        // Requests now are ignored; control must hold off a cycle
        if (state_reg.busy) begin
            state_next.busy = 1'b0; // (RULE_18)
            state_next.done = 1'b1;
            // Writes finish without data
            if (state_reg.pend_rd) begin
                state_next.rd_data = sram_rd_data_i;
            end
            state_next.pend_rd = 1'b0;
        end else if (data_req_i.valid) begin
            // Effective address per mode
            if (data_req_i.mode == MODE_DIRECT) begin
                a = data_req_i.direct; // (RULE_10)
            end else if (data_req_i.mode == MODE_IO) begin
                a = IO_BASE + {10'h000, data_req_i.field6}; // (RULE_09)
            end else begin
                a = eff_addr;
            end

            // Address and write data stand until the next access
            state_next.addr    = a;
            state_next.wr_data = data_req_i.wr_data;

            // Decode of the data space
            if (a < IO_BASE) begin
                // Register hit: done at once, no strobe
                state_next.target = TGT_REG; // (RULE_02)
                state_next.done   = 1'b1;
                if (data_req_i.write) begin
                    state_next.regs[a[4:0]] = data_req_i.wr_data;
                end else begin
                    state_next.rd_data = state_reg.regs[a[4:0]];
                end
            end else if (a < SRAM_BASE) begin
                // Strobe now, read data one cycle later
                state_next.target  = TGT_IO; // (RULE_03)
                state_next.done    = 1'b1;
                state_next.io_addr = 6'(a - IO_BASE);
                state_next.io_wr   = data_req_i.write;
                state_next.io_rd   = !data_req_i.write;
            end else if (a < DATA_END) begin
                // Busy for the second cycle
                state_next.target    = TGT_SRAM; // (RULE_03)
                state_next.busy      = 1'b1;
                state_next.pend_rd   = !data_req_i.write;
                state_next.sram_addr = 7'(a - SRAM_BASE);
                state_next.sram_wr   = data_req_i.write;
                state_next.sram_rd   = !data_req_i.write;
            end else begin
                // Outside the map: reads give zero, writes dropped
                state_next.target  = TGT_NONE;
                state_next.done    = 1'b1;
                state_next.rd_data = 8'h00;
            end

            // Pointer writeback last so it wins over a self-write
            if (ptr_update) begin
                state_next.regs[ptr_lo]         = new_ptr[7:0]; // (RULE_19)
                state_next.regs[ptr_lo + 5'h01] = new_ptr[15:8];
            end
        end

        // I/O read data lands one cycle after the strobe
        // Limitation: a read taken under the strobe gets this data
        if (state_reg.io_rd) begin
            state_next.rd_data = io_rd_data_i;
        end

        // Offset cut to the counter width; the sum wraps the same way
        rel = PC_WIDTH'(rel_offset_i);

        // Program counter, wraps within 1024 words
        case (pc_op_i)
            PC_SEQ:      state_next.pc = state_reg.pc + PC_WIDTH'(1); // (RULE_14)
            PC_POINTER:  state_next.pc = PC_WIDTH'({state_reg.regs[PTR_Z_LO + 1],
                                                    state_reg.regs[PTR_Z_LO]}); // (RULE_12)
            PC_RELATIVE: state_next.pc = state_reg.pc + rel + PC_WIDTH'(1); // (RULE_13)
            default:     state_next.pc = state_reg.pc;
        endcase

        // Constant table address: word from Z bits 15:1, byte from bit 0
        state_next.cst.word_addr = {state_reg.regs[PTR_Z_LO + 1],
                                    state_reg.regs[PTR_Z_LO][7:1]};
        state_next.cst.high_byte = state_reg.regs[PTR_Z_LO][0]; // (RULE_11)
    end

    // Single system clock, no divider
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin // (RULE_17)
        if (!rst_n_i) begin
            // No access yet: target shows none
            state_reg        <= '0;
            state_reg.regs   <= {NUM_REGS{REG_RESET_VAL}};
            state_reg.target <= TGT_NONE;
            state_reg.pc     <= PC_RESET_VAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operand outputs straight from state
    assign dst_operand_o        = state_reg.dst_q;
    assign source_operand_reg_o = state_reg.src_q;
    assign imm_reg_fault_o      = state_reg.imm_fault;

    // Data port result
    assign data_addr_o          = state_reg.addr;
    assign data_target_o        = state_reg.target;
    assign data_rd_o            = state_reg.rd_data;
    assign data_done_o          = state_reg.done;
    assign data_busy_o          = state_reg.busy;

    // I/O side
    assign io_wr_o              = state_reg.io_wr;
    assign io_rd_o              = state_reg.io_rd;
    assign io_addr_o            = state_reg.io_addr;
    assign io_wr_data_o         = state_reg.wr_data;

    // SRAM side
    assign sram_wr_o            = state_reg.sram_wr;
    assign sram_rd_o            = state_reg.sram_rd;
    assign sram_addr_o          = state_reg.sram_addr;
    assign sram_wr_data_o       = state_reg.wr_data;

    // Counter and constant address
    assign pc_o                 = state_reg.pc;
    assign const_addr_o         = state_reg.cst;

endmodule // cpu_regfile_address_gen

// ==== core/regfile_pkg.sv ====
package regfile_pkg;

    // Register file geometry
    localparam int unsigned NUM_REGS      = 32;
    localparam int unsigned IMM_REG_BASE  = 16;
    localparam int unsigned PTR_X_LO      = 26;
    localparam int unsigned PTR_Y_LO      = 28;
    localparam int unsigned PTR_Z_LO      = 30;

    // Data space map
    localparam logic [15:0] IO_BASE       = 16'h0020;
    localparam logic [15:0] SRAM_BASE     = 16'h0060;
    localparam logic [15:0] DATA_END      = 16'h00E0;
    localparam logic [7:0]  REG_RESET_VAL = 8'h00;
    localparam logic [9:0]  PC_RESET_VAL  = 10'h000;

    // SRAM access takes two clock cycles
    localparam int unsigned SRAM_CYCLES   = 2;

    // Addressing modes for one data access
    typedef enum logic [2:0] {
        MODE_DIRECT,
        MODE_IO,
        MODE_INDIRECT,
        MODE_DISP,
        MODE_PREDEC,
        MODE_POSTINC
    } addr_mode_t;

    // Program counter update sources
    typedef enum logic [1:0] {
        PC_SEQ,
        PC_POINTER,
        PC_RELATIVE,
        PC_HOLD
    } pc_op_t;

    // Target of a data-space decode
    typedef enum logic [1:0] {
        TGT_REG,
        TGT_IO,
        TGT_SRAM,
        TGT_NONE
    } target_t;

    // Register operation request from execution control
    typedef struct packed {
        logic       wr_en;
        logic       immediate;
        logic [4:0] dst_sel;
        logic [4:0] src_sel;
        logic [7:0] wr_data;
    } alu_req_t;

    // Data access request
    typedef struct packed {
        logic       valid;
        logic       write;
        addr_mode_t mode;
        logic [1:0] ptr_sel;   // 0 X, 1 Y, 2 Z
        logic [5:0] field6;    // Displacement or I/O address
        logic [15:0] direct;   // Second instruction word
        logic [7:0] wr_data;
    } data_req_t;

    // Program memory constant address
    typedef struct packed {
        logic [14:0] word_addr;
        logic        high_byte;
    } const_addr_t;

endpackage

// ==== core/ptr_adjust.sv ====
`timescale 1ns/10ps
module ptr_adjust
    import regfile_pkg::*;
#(
    parameter int unsigned WIDTH = 16
) (
    // Pointer value and mode
    input  wire logic [WIDTH-1:0] ptr_i,
    input  wire addr_mode_t       mode_i,
    input  wire logic [5:0]       disp_i,
    // Access address and pointer writeback
    output logic      [WIDTH-1:0] addr_o,
    output logic      [WIDTH-1:0] new_ptr_o,
    output logic                  update_o
);

    // Address and writeback per mode
    always_comb begin
        addr_o    = ptr_i;
        new_ptr_o = ptr_i;
        update_o  = 1'b0;
        case (mode_i)
            MODE_DISP: begin
                addr_o = ptr_i + WIDTH'(disp_i); // (RULE_05)
            end
            MODE_PREDEC: begin
                addr_o    = ptr_i - WIDTH'(1); // (RULE_07)
                new_ptr_o = ptr_i - WIDTH'(1);
                update_o  = 1'b1;
            end
            MODE_POSTINC: begin
                new_ptr_o = ptr_i + WIDTH'(1); // (RULE_08)
                update_o  = 1'b1;
            end
            default: begin
                addr_o = ptr_i; // (RULE_06)
            end
        endcase
    end

endmodule // ptr_adjust

// ==== test/cpu_regfile_address_gen_props.sv ====
`timescale 1ns/10ps
module cpu_regfile_address_gen_props
    import regfile_pkg::*;
#(
    parameter int unsigned PC_WIDTH = 10
) (
    // Clock and reset
    input wire logic                core_clk_i,
    input wire logic                rst_n_i,
    // Register and data ports
    input wire alu_req_t            alu_req_i,
    input wire logic                imm_reg_fault_o,
    input wire data_req_t           data_req_i,
    input wire logic [15:0]         data_addr_o,
    input wire target_t             data_target_o,
    input wire logic                data_done_o,
    input wire logic                data_busy_o,
    // Memory side strobes
    input wire logic                io_wr_o,
    input wire logic                io_rd_o,
    input wire logic [5:0]          io_addr_o,
    input wire logic                sram_wr_o,
    input wire logic                sram_rd_o,
    input wire logic [6:0]          sram_addr_o,
    // Program counter
    input wire pc_op_t              pc_op_i,
    input wire logic [11:0]         rel_offset_i,
    input wire logic [PC_WIDTH-1:0] pc_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Accepted request and wrapped next counter values
    logic                take;
    logic [PC_WIDTH-1:0] pc_inc;
    logic [PC_WIDTH-1:0] pc_rel;
    assign take   = data_req_i.valid && !data_busy_o;
    assign pc_inc = pc_o + 1'b1;
    assign pc_rel = pc_o + rel_offset_i[PC_WIDTH-1:0] + 1'b1;

    AST_IMM_LOW: assert property (alu_req_i.wr_en && alu_req_i.immediate
        && alu_req_i.dst_sel < 5'h10 |=> imm_reg_fault_o) else $error("low immediate not flagged");
    AST_IMM_HIGH: assert property (alu_req_i.immediate && alu_req_i.dst_sel >= 5'h10
        |=> !imm_reg_fault_o) else $error("high immediate flagged");
    AST_SRAM_TWO: assert property (sram_rd_o |-> data_busy_o
        ##1 (data_done_o && !data_busy_o)) else $error("sram access not two cycles");
    AST_SRAM_MAP: assert property ((sram_rd_o || sram_wr_o) |-> data_target_o == TGT_SRAM
        && {9'h000, sram_addr_o} == data_addr_o - SRAM_BASE) else $error("sram decode wrong");
    AST_DIRECT: assert property (take && data_req_i.mode == MODE_DIRECT
        |=> data_addr_o == $past(data_req_i.direct)) else $error("direct address wrong");
    AST_IO_FIELD: assert property (take && data_req_i.mode == MODE_IO
        |=> (io_rd_o || io_wr_o) && io_addr_o == $past(data_req_i.field6))
        else $error("io address wrong");
    AST_REG_MAP: assert property (data_done_o && data_target_o == TGT_REG
        |-> data_addr_o < IO_BASE) else $error("register target outside register range");
    AST_PC_STEP: assert property (pc_op_i == PC_SEQ
        |=> pc_o == $past(pc_inc)) else $error("pc step wrong");
    AST_PC_REL: assert property (pc_op_i == PC_RELATIVE
        |=> pc_o == $past(pc_rel)) else $error("relative pc wrong");
endmodule // cpu_regfile_address_gen_props

bind cpu_regfile_address_gen cpu_regfile_address_gen_props #(.PC_WIDTH(PC_WIDTH)) props_i (
    .core_clk_i, .rst_n_i, .alu_req_i, .imm_reg_fault_o, .data_req_i, .data_addr_o,
    .data_target_o, .data_done_o, .data_busy_o, .io_wr_o, .io_rd_o, .io_addr_o,
    .sram_wr_o, .sram_rd_o, .sram_addr_o, .pc_op_i, .rel_offset_i, .pc_o
);

// ==== test/mem_partner.sv ====
`timescale 1ns/10ps
module mem_partner (
    // Clock
    input  wire logic       core_clk_i,
    // I/O side
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [5:0] io_addr_i,
    input  wire logic [7:0] io_wr_data_i,
    output logic      [7:0] io_rd_data_o,
    // SRAM side
    input  wire logic       sram_wr_i,
    input  wire logic       sram_rd_i,
    input  wire logic [6:0] sram_addr_i,
    input  wire logic [7:0] sram_wr_data_i,
    output logic      [7:0] sram_rd_data_o
);
    logic [7:0] io_mem [64];
    logic [7:0] sram_mem [128];
    logic [7:0] idle_reg = 8'h5A;

    // Storage; idle pattern moves so stale data never looks valid
    always @(posedge core_clk_i) begin
        idle_reg <= idle_reg + 8'h3B;
        if (io_wr_i)
            io_mem[io_addr_i] <= io_wr_data_i;
        if (sram_wr_i)
            sram_mem[sram_addr_i] <= sram_wr_data_i;
    end

    // Read data only while a read strobe stands
    assign io_rd_data_o   = io_rd_i ? io_mem[io_addr_i] : idle_reg;
    assign sram_rd_data_o = sram_rd_i ? sram_mem[sram_addr_i] : ~idle_reg;
endmodule // mem_partner

// ==== test/cpu_regfile_address_gen_tb_top.sv ====
`timescale 1ns/10ps
module cpu_regfile_address_gen_tb_top import regfile_pkg::*;;
    typedef struct packed {
        addr_mode_t  m;
        logic [1:0]  p;
        logic [5:0]  f;
        logic [15:0] d;
        logic        w;
        logic [7:0]  wd;
        logic [15:0] ea;
        target_t     t;
        logic [7:0]  rd;
    } row_t;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    alu_req_t alu_req_i = '0;
    data_req_t data_req_i = '0;
    pc_op_t pc_op_i = PC_HOLD;
    logic [11:0] rel_offset_i = 12'h000;
    logic [7:0] dst_operand_o, source_operand_reg_o, data_rd_o, io_wr_data_o, io_rd_data_i;
    logic [7:0] sram_wr_data_o, sram_rd_data_i;
    logic imm_reg_fault_o, data_done_o, data_busy_o, io_wr_o, io_rd_o, sram_wr_o, sram_rd_o;
    logic [15:0] data_addr_o;
    target_t data_target_o;
    logic [5:0] io_addr_o;
    logic [6:0] sram_addr_o;
    logic [9:0] pc_o;
    const_addr_t const_addr_o;
    int errors = 0;
    int checked = 0;
    logic [7:0] pv [6] = '{8'h65, 8'h00, 8'h70, 8'h00, 8'h23, 8'h01};
    // Access rows: mode, pointer, field, word, write, data, address, target, read
    row_t rows [13] = '{
        '{MODE_DIRECT, 2'h0, 6'h00, 16'h0065, 1'b1, 8'hA5, 16'h0065, TGT_SRAM, 8'h00},
        '{MODE_INDIRECT, 2'h0, 6'h00, 16'h0000, 1'b0, 8'h00, 16'h0065, TGT_SRAM, 8'hA5},
        '{MODE_DISP, 2'h1, 6'h3F, 16'h0000, 1'b1, 8'h3C, 16'h00AF, TGT_SRAM, 8'h00},
        '{MODE_DIRECT, 2'h0, 6'h00, 16'h00AF, 1'b0, 8'h00, 16'h00AF, TGT_SRAM, 8'h3C},
        '{MODE_POSTINC, 2'h0, 6'h00, 16'h0000, 1'b1, 8'h5A, 16'h0065, TGT_SRAM, 8'h00},
        '{MODE_PREDEC, 2'h0, 6'h00, 16'h0000, 1'b0, 8'h00, 16'h0065, TGT_SRAM, 8'h5A},
        '{MODE_DISP, 2'h0, 6'h3F, 16'h0000, 1'b0, 8'h00, 16'h0065, TGT_SRAM, 8'h5A},
        '{MODE_DISP, 2'h2, 6'h01, 16'h0000, 1'b0, 8'h00, 16'h0124, TGT_NONE, 8'h00},
        '{MODE_IO, 2'h0, 6'h3F, 16'h0000, 1'b1, 8'hC3, 16'h005F, TGT_IO, 8'h00},
        '{MODE_DIRECT, 2'h0, 6'h00, 16'h005F, 1'b0, 8'h00, 16'h005F, TGT_IO, 8'hC3},
        '{MODE_DIRECT, 2'h0, 6'h00, 16'h0003, 1'b1, 8'h77, 16'h0003, TGT_REG, 8'h00},
        '{MODE_DIRECT, 2'h0, 6'h00, 16'h00E0, 1'b0, 8'h00, 16'h00E0, TGT_NONE, 8'h00},
        '{MODE_IO, 2'h0, 6'h3F, 16'h0000, 1'b0, 8'h00, 16'h005F, TGT_IO, 8'hC3}
    };

    cpu_regfile_address_gen #(.PC_WIDTH(10)) dut (
        .core_clk_i, .rst_n_i, .alu_req_i, .dst_operand_o, .source_operand_reg_o,
        .imm_reg_fault_o, .data_req_i, .data_addr_o, .data_target_o, .data_rd_o, .data_done_o,
        .data_busy_o, .io_wr_o, .io_rd_o, .io_addr_o, .io_wr_data_o, .io_rd_data_i, .sram_wr_o,
        .sram_rd_o, .sram_addr_o, .sram_wr_data_o, .sram_rd_data_i, .pc_op_i, .rel_offset_i,
        .pc_o, .const_addr_o
    );
    mem_partner partner (
        .core_clk_i, .io_wr_i(io_wr_o), .io_rd_i(io_rd_o), .io_addr_i(io_addr_o),
        .io_wr_data_i(io_wr_data_o), .io_rd_data_o(io_rd_data_i), .sram_wr_i(sram_wr_o),
        .sram_rd_i(sram_rd_o), .sram_addr_i(sram_addr_o), .sram_wr_data_i(sram_wr_data_o),
        .sram_rd_data_o(sram_rd_data_i)
    );

    // Clock
    always #5 core_clk_i = ~core_clk_i;

    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // One ALU request, outputs land at the following falling edge
    task automatic alu(input logic i, input logic [4:0] d, input logic [4:0] s,
                       input logic [7:0] v, input logic we);
        @(negedge core_clk_i);
        alu_req_i = '{we, i, d, s, v};
        @(negedge core_clk_i);
        alu_req_i = '0;
    endtask
    // One data access; waits for done, then one cycle so read data has settled
    task automatic acc(input row_t r);
        int i;
        @(negedge core_clk_i);
        data_req_i = '{1'b1, r.w, r.m, r.p, r.f, r.d, r.wd};
        for (i = 0; i < 4 && data_done_o !== 1'b1; i++) begin
            @(negedge core_clk_i);
            data_req_i = '0;
        end
        chk8("done", 8'h01, {7'h00, data_done_o});
        @(negedge core_clk_i);
    endtask
    task automatic pcs(input pc_op_t op, input logic [11:0] k, input logic [9:0] e);
        @(negedge core_clk_i);
        pc_op_i = op;
        rel_offset_i = k;
        @(negedge core_clk_i);
        pc_op_i = PC_HOLD;
        chk16("pc", {6'h00, e}, {6'h00, pc_o});
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #20000;
        errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (6) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        @(negedge core_clk_i);
        chk16("pc reset", 16'h0000, {6'h00, pc_o});
        chk8("target reset", {6'h00, TGT_NONE}, {6'h00, data_target_o});
        foreach (pv[i])
            alu(1'b0, 5'h1A + 5'(i), 5'h00, pv[i], 1'b1);
        foreach (rows[i]) begin
            acc(rows[i]);
            chk16("addr", rows[i].ea, data_addr_o);
            chk8("target", {6'h00, rows[i].t}, {6'h00, data_target_o});
            if (!rows[i].w)
                chk8("read", rows[i].rd, data_rd_o);
        end
        // Pointer back at its start after increment then decrement
        alu(1'b0, 5'h1A, 5'h1B, 8'h00, 1'b0);
        chk8("x low", 8'h65, dst_operand_o);
        chk8("x high", 8'h00, source_operand_reg_o);
        // Immediate writes: upper half only
        alu(1'b1, 5'h10, 5'h00, 8'h11, 1'b1);
        chk8("fault high", 8'h00, {7'h00, imm_reg_fault_o});
        alu(1'b1, 5'h0F, 5'h00, 8'hFF, 1'b1);
        chk8("fault low", 8'h01, {7'h00, imm_reg_fault_o});
        alu(1'b0, 5'h0F, 5'h10, 8'h00, 1'b0);
        chk8("r15", 8'h00, dst_operand_o);
        chk8("r16", 8'h11, source_operand_reg_o);
        // Two operands out and result back in one cycle
        alu(1'b0, 5'h10, 5'h03, 8'h22, 1'b1);
        chk8("dst pre", 8'h11, dst_operand_o);
        chk8("src", 8'h77, source_operand_reg_o);
        alu(1'b0, 5'h10, 5'h03, 8'h00, 1'b0);
        chk8("dst post", 8'h22, dst_operand_o);
        chk8("src kept", 8'h77, source_operand_reg_o);
        // Pointer writes its own low byte; the increment must win
        alu(1'b0, 5'h1A, 5'h00, 8'h1A, 1'b1);
        acc('{MODE_POSTINC, 2'h0, 6'h00, 16'h0000, 1'b1, 8'h99, 16'h001A, TGT_REG,
              8'h00});
        chk16("self addr", 16'h001A, data_addr_o);
        alu(1'b0, 5'h1A, 5'h00, 8'h00, 1'b0);
        chk8("x self", 8'h1B, dst_operand_o);
        chk16("const", 16'h0123, const_addr_o);
        pcs(PC_POINTER, 12'h000, 10'h123);
        pcs(PC_RELATIVE, 12'h800, 10'h124);
        pcs(PC_RELATIVE, 12'hFFE, 10'h123);
        pcs(PC_RELATIVE, 12'h2DB, 10'h3FF);
        pcs(PC_SEQ, 12'h000, 10'h000);
        // Reset in mid-run clears pointers, target and constant address
        rst_n_i = 1'b0;
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        chk16("pc mid reset", 16'h0000, {6'h00, pc_o});
        chk16("const mid reset", 16'h0000, const_addr_o);
        chk8("target mid reset", {6'h00, TGT_NONE}, {6'h00, data_target_o});
        alu(1'b0, 5'h1E, 5'h1F, 8'h00, 1'b0);
        chk8("z low reset", 8'h00, dst_operand_o);
        chk8("z high reset", 8'h00, source_operand_reg_o);
        finish_test();
    end
endmodule // cpu_regfile_address_gen_tb_top
